//--- rtl/rfpd_defs.svh
// Offsets, field positions, reset values and constants of the PLL divider configuration
`ifndef RFPD_DEFS_SVH
`define RFPD_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses on the serial port
// ----------------------------------------------------------------
`define RFPD_ADDR_W              7
`define RFPD_ADDR_ZERO_HIGH      7'h04
`define RFPD_ADDR_ZERO_LOW       7'h05
`define RFPD_ADDR_ONE_HIGH       7'h06
`define RFPD_ADDR_ONE_LOW        7'h07

// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define RFPD_BYTE_W              8
`define RFPD_FRAC_BITS           13
`define RFPD_LOW_FIELD_MSB       7
`define RFPD_LOW_FIELD_LSB       3
`define RFPD_INT_W               5
`define RFPD_INT_PART            5'h13
`define RFPD_WORD_W              18
`define RFPD_RESET_BYTE          8'h00
`define RFPD_UNMAPPED_BYTE       8'h00
`define RFPD_CMD_WRITE_BIT       7
`define RFPD_BIT_CNT_W           3
`define RFPD_BIT_LAST            3'h7

`endif

//--- rtl/rfpd_pkg.sv
// Types shared by the PLL divider configuration block
`include "rfpd_defs.svh"

package rfpd_pkg;

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RFPD_SPI_CMD  = 2'b00,
		RFPD_SPI_DATA = 2'b01,
		RFPD_SPI_DONE = 2'b10
	} rfpd_spi_state_t;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic cs_n;
	} rfpd_spi_in_t;

	typedef struct packed {
		logic                            valid;
		logic [`RFPD_ADDR_W-1:0]         addr;
		logic [`RFPD_BYTE_W-1:0]         data;
	} rfpd_wr_t;

	// ----------------------------------------------------------------
	// Divider ratios
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [`RFPD_FRAC_BITS-1:0] zero;
		logic [`RFPD_FRAC_BITS-1:0] one;
	} rfpd_ratio_t;

endpackage : rfpd_pkg

//--- rtl/rfpd_pll_divider_config.sv
// PLL divider ratio registers of the RF transmitter, loaded over the serial port
//
// Contract
// - Zero-bit ratio: $04[7:0] high, $05[7:3] low
// - Carrier equals crystal times 19 plus ratio/8192
// - Transmitter reset clears zero-bit ratio
// - One-bit ratio: $06[7:0] high, $07[7:3] low
// - Serial writes store byte at addressed register
// - One-bit carrier uses the same equation
`include "rfpd_defs.svh"

module rfpd_pll_divider_config #(
	parameter int FRAC_BITS = `RFPD_FRAC_BITS,  // Fractional ratio width
	parameter int WORD_W    = `RFPD_WORD_W      // Integer plus fraction width
) (
	input  wire logic                  clk,                     // 250 MHz clock
	input  wire logic                  reset_n,                 // Async reset, active low
	input  wire rfpd_pkg::rfpd_spi_in_t spi,                    // Serial port inputs
	output logic                       miso,                    // Serial data out
	input  wire logic                  rf_reset,                // Transmitter reset, sync
	input  wire logic                  tx_data_bit,             // Bit being sent
	input  wire logic                  fsk_mode,                // 1 FSK, 0 ASK
	output logic [FRAC_BITS-1:0]       zero_bit_divider_ratio,  // Ratio for a zero bit
	output logic [FRAC_BITS-1:0]       one_bit_divider_ratio,   // Ratio for a one bit
	output logic [WORD_W-1:0]          zero_divider_word,       // 19*8192 + zero ratio
	output logic [WORD_W-1:0]          one_divider_word,        // 19*8192 + one ratio
	output logic [WORD_W-1:0]          active_divider_word      // Word for the PLL now
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (FRAC_BITS != `RFPD_FRAC_BITS || WORD_W != FRAC_BITS + `RFPD_INT_W) begin : g_chk
		$error("rfpd_pll_divider_config: unsupported ratio widths");
	end

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	rfpd_pkg::rfpd_wr_t           wr;
	logic [`RFPD_ADDR_W-1:0]      rd_addr;
	logic [`RFPD_BYTE_W-1:0]      rd_data;

	rfpd_spi_slave u_spi (
		.clk     (clk),
		.reset_n (reset_n),
		.spi     (spi),
		.rd_data (rd_data),
		.rd_addr (rd_addr),
		.miso    (miso),
		.wr      (wr)
	);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [`RFPD_BYTE_W-1:0]  zero_high, next_zero_high;
	logic [`RFPD_BYTE_W-1:0]  zero_low,  next_zero_low;
	logic [`RFPD_BYTE_W-1:0]  one_high,  next_one_high;
	logic [`RFPD_BYTE_W-1:0]  one_low,   next_one_low;
	rfpd_pkg::rfpd_ratio_t    next_ratio;
	logic [WORD_W-1:0]        next_zero_word;
	logic [WORD_W-1:0]        next_one_word;
	logic [WORD_W-1:0]        next_active_word;

	function automatic logic [FRAC_BITS-1:0] ratio_of(
		input logic [`RFPD_BYTE_W-1:0] high,
		input logic [`RFPD_BYTE_W-1:0] low
	);
		ratio_of = {high, low[`RFPD_LOW_FIELD_MSB:`RFPD_LOW_FIELD_LSB]};
	endfunction : ratio_of

	// Integer part concatenated above the fraction is 19*8192 + ratio
	function automatic logic [WORD_W-1:0] word_of(input logic [FRAC_BITS-1:0] ratio);
		word_of = {`RFPD_INT_PART, ratio};
	endfunction : word_of

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped addresses read as zero
	always_comb begin
		case (rd_addr)
			`RFPD_ADDR_ZERO_HIGH: rd_data = zero_high;
			`RFPD_ADDR_ZERO_LOW:  rd_data = zero_low;
			`RFPD_ADDR_ONE_HIGH:  rd_data = one_high;
			`RFPD_ADDR_ONE_LOW:   rd_data = one_low;
			default:              rd_data = `RFPD_UNMAPPED_BYTE;
		endcase
	end

	// ----------------------------------------------------------------
	// Next values
	// ----------------------------------------------------------------
	always_comb begin
		next_zero_high = zero_high;
		next_zero_low  = zero_low;
		next_one_high  = one_high;
		next_one_low   = one_low;
		if (rf_reset) begin
			// Transmitter reset outranks a write in the same cycle
			next_zero_high = `RFPD_RESET_BYTE;
			next_zero_low  = `RFPD_RESET_BYTE;
			next_one_high  = `RFPD_RESET_BYTE;
			next_one_low   = `RFPD_RESET_BYTE;
		end else if (wr.valid) begin
			case (wr.addr)
				`RFPD_ADDR_ZERO_HIGH: next_zero_high = wr.data;
				`RFPD_ADDR_ZERO_LOW:  next_zero_low  = wr.data;
				`RFPD_ADDR_ONE_HIGH:  next_one_high  = wr.data;
				`RFPD_ADDR_ONE_LOW:   next_one_low   = wr.data;
				default:              next_zero_high = zero_high;
			endcase
		end
		next_ratio.zero  = ratio_of(next_zero_high, next_zero_low);
		next_ratio.one   = ratio_of(next_one_high, next_one_low);
		next_zero_word   = word_of(next_ratio.zero);
		next_one_word    = word_of(next_ratio.one);
		// ASK keys the carrier on the one-bit ratio only
		next_active_word = (fsk_mode && !tx_data_bit) ? next_zero_word : next_one_word;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			zero_high              <= `RFPD_RESET_BYTE;
			zero_low               <= `RFPD_RESET_BYTE;
			one_high               <= `RFPD_RESET_BYTE;
			one_low                <= `RFPD_RESET_BYTE;
			zero_bit_divider_ratio <= '0;
			one_bit_divider_ratio  <= '0;
			zero_divider_word      <= {`RFPD_INT_PART, {FRAC_BITS{1'b0}}};
			one_divider_word       <= {`RFPD_INT_PART, {FRAC_BITS{1'b0}}};
			active_divider_word    <= {`RFPD_INT_PART, {FRAC_BITS{1'b0}}};
		end else begin
			zero_high              <= next_zero_high;
			zero_low               <= next_zero_low;
			one_high               <= next_one_high;
			one_low                <= next_one_low;
			zero_bit_divider_ratio <= next_ratio.zero;
			one_bit_divider_ratio  <= next_ratio.one;
			zero_divider_word      <= next_zero_word;
			one_divider_word       <= next_one_word;
			active_divider_word    <= next_active_word;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_write(logic [`RFPD_ADDR_W-1:0] a);
		wr.valid && !rf_reset && wr.addr == a;
	endsequence

	sequence s_unmapped;
		wr.valid && !rf_reset
		&& (wr.addr < `RFPD_ADDR_ZERO_HIGH || wr.addr > `RFPD_ADDR_ONE_LOW);
	endsequence

	AST_ZERO_HIGH: assert property (s_write(`RFPD_ADDR_ZERO_HIGH) |=>
		zero_bit_divider_ratio[FRAC_BITS-1:5] == $past(wr.data))
		else $error("zero ratio high byte not taken from register 04");

	AST_ZERO_LOW: assert property (s_write(`RFPD_ADDR_ZERO_LOW) |=>
		zero_bit_divider_ratio[4:0] == $past(wr.data[7:3])
		&& $stable(zero_bit_divider_ratio[FRAC_BITS-1:5]))
		else $error("zero ratio low bits not taken from register 05 bits 7-3");

	AST_ONE_MAP: assert property (s_write(`RFPD_ADDR_ONE_HIGH) |=>
		one_bit_divider_ratio[FRAC_BITS-1:5] == $past(wr.data))
		else $error("one ratio high byte not taken from register 06");

	AST_ONE_LOW: assert property (s_write(`RFPD_ADDR_ONE_LOW) |=>
		one_bit_divider_ratio[4:0] == $past(wr.data[7:3])
		&& $stable(one_bit_divider_ratio[FRAC_BITS-1:5]))
		else $error("one ratio low bits not taken from register 07 bits 7-3");

	AST_ZERO_WORD: assert property (zero_divider_word ==
		WORD_W'(19 * 8192) + WORD_W'(zero_bit_divider_ratio))
		else $error("zero divider word is not 19*8192 plus ratio");

	AST_ONE_WORD: assert property (one_divider_word ==
		WORD_W'(19 * 8192) + WORD_W'(one_bit_divider_ratio))
		else $error("one divider word is not 19*8192 plus ratio");

	AST_RF_RESET: assert property (rf_reset |=> zero_bit_divider_ratio == '0
		&& zero_divider_word == WORD_W'(19 * 8192))
		else $error("transmitter reset did not clear zero ratio");

	AST_READBACK: assert property (s_write(`RFPD_ADDR_ZERO_LOW) ##1
		(!wr.valid && !rf_reset) [*2] |-> zero_low == $past(wr.data, 2))
		else $error("written byte not held at register 05");

	AST_HOLD: assert property (!wr.valid && !rf_reset |=>
		$stable(zero_bit_divider_ratio) && $stable(one_bit_divider_ratio))
		else $error("ratio changed without a write or reset");

	AST_ACTIVE: assert property (fsk_mode && !tx_data_bit && !rf_reset && !wr.valid
		|=> active_divider_word == zero_divider_word)
		else $error("FSK zero bit did not select zero divider word");

	AST_UNMAPPED: assert property (s_unmapped |=>
		$stable(zero_bit_divider_ratio) && $stable(one_bit_divider_ratio))
		else $error("write to an unmapped address changed a ratio");

	AST_ONE_CLEAR: assert property (rf_reset |=> one_bit_divider_ratio == '0
		&& one_divider_word == WORD_W'(19 * 8192))
		else $error("transmitter reset did not clear one ratio");

	AST_ASK_ONE: assert property (!fsk_mode
		|=> active_divider_word == one_divider_word)
		else $error("ASK did not select one divider word");

	AST_FSK_ONE: assert property (fsk_mode && tx_data_bit
		|=> active_divider_word == one_divider_word)
		else $error("FSK one bit did not select one divider word");

endmodule : rfpd_pll_divider_config

//--- rtl/rfpd_spi_slave.sv
// Serial register port: command byte then one data byte, MSB first
`include "rfpd_defs.svh"

module rfpd_spi_slave (
	input  wire logic                     clk,      // System clock
	input  wire logic                     reset_n,  // Async reset, active low
	input  wire rfpd_pkg::rfpd_spi_in_t   spi,      // Serial clock, data in, select
	input  wire logic [`RFPD_BYTE_W-1:0]  rd_data,  // Read data for rd_addr
	output logic      [`RFPD_ADDR_W-1:0]  rd_addr,  // Address of current frame
	output logic                          miso,     // Serial data out
	output rfpd_pkg::rfpd_wr_t            wr        // One-cycle write event
);

	rfpd_pkg::rfpd_spi_state_t      state, next_state;
	logic                           sck_q, next_sck_q;
	logic [`RFPD_BIT_CNT_W-1:0]     cnt, next_cnt;
	logic [`RFPD_BYTE_W-1:0]        rx, next_rx;
	logic [`RFPD_BYTE_W-1:0]        tx, next_tx;
	logic                           is_write, next_is_write;
	logic                           load_tx, next_load_tx;
	logic [`RFPD_ADDR_W-1:0]        next_rd_addr;
	rfpd_pkg::rfpd_wr_t             next_wr;
	logic                           rise;
	logic                           fall;

	assign rise = spi.sck & ~sck_q;
	assign fall = ~spi.sck & sck_q;
	assign miso = tx[`RFPD_BYTE_W-1];

	always_comb begin
		next_state    = state;
		next_sck_q    = spi.sck;
		next_cnt      = cnt;
		next_rx       = rx;
		next_tx       = tx;
		next_is_write = is_write;
		next_load_tx  = 1'b0;
		next_rd_addr  = rd_addr;
		next_wr       = '0;
		if (load_tx) begin
			next_tx = rd_data;
		end
		if (spi.cs_n) begin
			// Deselect aborts any partial frame
			next_state = rfpd_pkg::RFPD_SPI_CMD;
			next_cnt   = '0;
		end else if (rise) begin
			next_rx  = {rx[`RFPD_BYTE_W-2:0], spi.mosi};
			next_cnt = cnt + 1'b1;
			if (cnt == `RFPD_BIT_LAST) begin
				case (state)
					rfpd_pkg::RFPD_SPI_CMD: begin
						next_is_write = rx[`RFPD_CMD_WRITE_BIT-1];
						next_rd_addr  = {rx[`RFPD_ADDR_W-2:0], spi.mosi};
						next_load_tx  = 1'b1;
						next_state    = rfpd_pkg::RFPD_SPI_DATA;
					end
					rfpd_pkg::RFPD_SPI_DATA: begin
						next_wr.valid = is_write;
						next_wr.addr  = rd_addr;
						next_wr.data  = {rx[`RFPD_BYTE_W-2:0], spi.mosi};
						next_state    = rfpd_pkg::RFPD_SPI_DONE;
					end
					default: begin
						next_state = rfpd_pkg::RFPD_SPI_DONE;
					end
				endcase
			end
		end else if (fall && state == rfpd_pkg::RFPD_SPI_DATA && !load_tx && cnt != '0) begin
			// Fall after the command byte keeps bit 7 up for the first data rise
			next_tx = {tx[`RFPD_BYTE_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state    <= rfpd_pkg::RFPD_SPI_CMD;
			sck_q    <= 1'b0;
			cnt      <= '0;
			rx       <= '0;
			tx       <= '0;
			is_write <= 1'b0;
			load_tx  <= 1'b0;
			rd_addr  <= '0;
			wr       <= '0;
		end else begin
			state    <= next_state;
			sck_q    <= next_sck_q;
			cnt      <= next_cnt;
			rx       <= next_rx;
			tx       <= next_tx;
			is_write <= next_is_write;
			load_tx  <= next_load_tx;
			rd_addr  <= next_rd_addr;
			wr       <= next_wr;
		end
	end

endmodule : rfpd_spi_slave

//--- tb/rfpd_host_model.sv
// Host side of the serial register port: write and read frames in SPI mode 0
`include "rfpd_defs.svh"

module rfpd_host_model (
	input  wire logic              clk,   // System clock
	output rfpd_pkg::rfpd_spi_in_t spi,   // Serial clock, data, select
	input  wire logic              miso   // Serial data from device
);
	timeunit 1ns;
	timeprecision 100ps;

	// Device needs each sck phase to last at least 3 clk cycles
	localparam int HALF = 4;

	logic [15:0] rx_word;

	initial spi = '{sck: 1'b0, mosi: 1'b0, cs_n: 1'b1};

	// ----------------------------------------------------------------
	// Frame: MSB first, sck idle low, stands still between frames
	// ----------------------------------------------------------------
	task automatic frame(input logic [15:0] word, input int nbits);
		for (int i = 15; i > 15 - nbits; i--) begin
			@(posedge clk);
			spi.cs_n <= 1'b0;
			spi.mosi <= word[i];
			repeat (HALF) @(posedge clk);
			rx_word = {rx_word[14:0], miso};
			spi.sck <= 1'b1;
			repeat (HALF) @(posedge clk);
			spi.sck <= 1'b0;
		end
		repeat (HALF) @(posedge clk);
		spi.cs_n <= 1'b1;
		// Released line shows no stale value
		spi.mosi <= ~spi.mosi;
		repeat (3) @(posedge clk);
	endtask : frame

	task automatic write(input logic [6:0] addr, input logic [7:0] data);
		logic [7:0] d;
		d = data;
		if (addr == `RFPD_ADDR_ZERO_LOW)
			d[2:0] = 3'b100;
		frame({1'b1, addr, d}, 16);
	endtask : write

	task automatic read(input logic [6:0] addr, output logic [7:0] data);
		frame({1'b0, addr, 8'h00}, 16);
		data = rx_word[7:0];
	endtask : read

endmodule : rfpd_host_model

//--- tb/tb.sv
// Self-checking testbench for the PLL divider configuration block
`include "rfpd_defs.svh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [17:0] BASE = 18'(19 * 8192);  // Integer part of the divider

	logic                   clk         = 1'b0;
	logic                   reset_n     = 1'b0;
	logic                   rf_reset    = 1'b0;
	logic                   tx_data_bit = 1'b0;
	logic                   fsk_mode    = 1'b0;
	rfpd_pkg::rfpd_spi_in_t spi;
	logic                   miso;
	logic [12:0]            zero_ratio;
	logic [12:0]            one_ratio;
	logic [17:0]            zero_word;
	logic [17:0]            one_word;
	logic [17:0]            active_word;
	logic [7:0]             rd_byte;
	int                     n_mismatch  = 0;
	int                     n_compared  = 0;

	always #2 clk = ~clk;

	rfpd_host_model i_host (
		.clk  (clk),
		.spi  (spi),
		.miso (miso)
	);

	rfpd_pll_divider_config i_dut (
		.clk                    (clk),
		.reset_n                (reset_n),
		.spi                    (spi),
		.miso                   (miso),
		.rf_reset               (rf_reset),
		.tx_data_bit            (tx_data_bit),
		.fsk_mode               (fsk_mode),
		.zero_bit_divider_ratio (zero_ratio),
		.one_bit_divider_ratio  (one_ratio),
		.zero_divider_word      (zero_word),
		.one_divider_word       (one_word),
		.active_divider_word    (active_word)
	);

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	task automatic check_all(input logic [12:0] zr, input logic [12:0] orr);
		check("zero_bit_divider_ratio", 18'(zero_ratio), 18'(zr));
		check("one_bit_divider_ratio", 18'(one_ratio), 18'(orr));
		check("zero_divider_word", zero_word, BASE + 18'(zr));
		check("one_divider_word", one_word, BASE + 18'(orr));
	endtask : check_all

	task automatic complete_run();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		check_all(13'h0000, 13'h0000);
		$display("test reset values done");

		i_host.write(`RFPD_ADDR_ZERO_HIGH, 8'hA5);
		i_host.write(`RFPD_ADDR_ZERO_LOW, 8'hDC);
		check_all({8'hA5, 5'h1B}, 13'h0000);
		$display("test zero-bit ratio done");

		// Top of the field: all thirteen bits set
		i_host.write(`RFPD_ADDR_ONE_HIGH, 8'hFF);
		i_host.write(`RFPD_ADDR_ONE_LOW, 8'hFC);
		check_all({8'hA5, 5'h1B}, 13'h1FFF);
		$display("test one-bit ratio done");

		for (int m = 0; m < 4; m++) begin
			fsk_mode    <= m[1];
			tx_data_bit <= m[0];
			repeat (3) @(posedge clk);
			// Only an FSK zero bit uses the zero-bit word
			check("active_divider_word", active_word,
				(m == 2) ? BASE + 18'h014BB : BASE + 18'h01FFF);
		end
		$display("test modulation select done");

		i_host.write(7'h03, 8'h00);
		i_host.write(7'h08, 8'h00);
		i_host.frame({1'b1, `RFPD_ADDR_ZERO_HIGH, 8'h00}, 12);
		check_all({8'hA5, 5'h1B}, 13'h1FFF);
		i_host.read(`RFPD_ADDR_ZERO_HIGH, rd_byte);
		check("pll_zero_ratio_high", 18'(rd_byte), 18'h000A5);
		i_host.read(`RFPD_ADDR_ZERO_LOW, rd_byte);
		check("pll_zero_ratio_low", 18'(rd_byte), 18'h000DC);
		i_host.read(`RFPD_ADDR_ONE_LOW, rd_byte);
		check("pll_one_ratio_low", 18'(rd_byte), 18'h000FC);
		i_host.read(7'h03, rd_byte);
		check("unmapped register 03", 18'(rd_byte), 18'h00000);
		$display("test ignored writes and readback done");

		@(posedge clk);
		rf_reset <= 1'b1;
		@(posedge clk);
		rf_reset <= 1'b0;
		repeat (2) @(posedge clk);
		check_all(13'h0000, 13'h0000);
		i_host.write(`RFPD_ADDR_ONE_HIGH, 8'h12);
		check_all(13'h0000, {8'h12, 5'h00});
		$display("test transmitter reset done");

		complete_run();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("watchdog expired");
		complete_run();
	end

endmodule : tb
